/* rtl/charger_command_register_bank.sv */
`timescale 1ns/1ps
// command register bank: status, current, voltage, alarm and version words
// Notes on behaviour
// - bit 11 shows live thermistor underrange
// - accepted alarm sets inhibit; alarm never clears
// - inhibit cleared by defaults, absences, valid pair
// - bit 14 shows battery presence
// - bit 15 shows adapter power presence
// - status word read only; write nacked
// - current request 16-bit mA, resets zero
// - current above maximum uses programmed maximum
// - current hffff selects maximum safe current
// - voltage request 16-bit mV, resets zero
// - voltage above maximum clamps to maximum
// - voltage hffff selects device maximum voltage
// - current, voltage, alarm words nack reads
// - upper alarm bit set stops charging
// - upper alarm zeros have no effect
// - alarm bit 11 and lower ignored
// - version word returns fixed code
// - wake-up plus stop alarm goes not-charging
module charger_command_register_bank
(
   input  wire logic                      REF_CLK,
   input  wire logic                      RST_N,
   input  wire charger_cmd_pkg::cmd_req_t CMD_REQ,
   input  wire charger_cmd_pkg::sense_t   SENSE,
   input  wire logic                      DEFAULTS_RESET,
   input  wire logic                      IN_WAKEUP,
   input  wire logic [15:0]               MAX_CURRENT,
   input  wire logic [15:0]               MAX_VOLTAGE,
   input  wire logic [15:0]               SAFE_CURRENT,
   input  wire logic [15:0]               DEVICE_MAX_VOLTAGE,
   output charger_cmd_pkg::cmd_rsp_t      CMD_RSP,
   output logic [15:0]                    CURRENT_SETTING,
   output logic [15:0]                    VOLTAGE_SETTING,
   output logic                           CURRENT_AUTO,
   output logic                           VOLTAGE_AUTO,
   output logic                           STOP_CHARGE,
   output logic                           GO_NOT_CHARGING,
   output logic                           PAIR_VALID,
   output logic                           ALARM_INHIBITED
);
   // synchronised sense levels
   logic therm_under_s;      // thermistor underrange, synced
   logic pwr_fail_s;         // power-fail comparator, synced
   logic batt_s;             // battery presence, synced
   logic adapter_s;          // adapter power presence, synced

   // raw request words
   logic [15:0] current_req_r;  // last current request
   logic [15:0] voltage_req_r;  // last voltage request
   logic        cur_seen_r;     // current written since last clear
   logic        vol_seen_r;     // voltage written since last clear
   logic        alarm_inh_r;    // alarm inhibited flag
   logic [15:0] status_word;    // assembled status word

   // decoded strobes
   logic wr_cur;      // current request write
   logic wr_vol;      // voltage request write
   logic wr_alarm;    // alarm warning write
   logic alarm_stop;  // alarm with an upper nibble bit set
   logic pair_done;   // both halves of the pair now present
   logic inh_clear;   // any clearing cause for the inhibit flag

   // clamp a request: maximum code passes as auto, above limit is limited
   function automatic logic [15:0] clamp_req(input logic [15:0] req,
                                             input logic [15:0] lim,
                                             input logic [15:0] auto_val);
      // auto code first, so it never reads as an over-limit request
      if (req == charger_cmd_pkg::REQ_MAXIMUM)
         clamp_req = auto_val;
      else if (req > lim)
         clamp_req = lim;
      else
         clamp_req = req;
   endfunction

   // compare command codes for a write or read
   function automatic logic is_cmd(input charger_cmd_pkg::cmd_req_t r,
                                   input logic [7:0] code,
                                   input logic wr);
      is_cmd = r.valid && (r.cmd == code) && (r.write == wr);
   endfunction

   // sense inputs come from the analog side, so each is synchronised
   // the filter costs four cycles of latency on each sensed status bit; the
   // sensed levels move slowly, so the delay was traded for status bits
   // that never show a half-settled value on a read
   // thermistor underrange level
   level_sync u_sync_therm
   (
      .REF_CLK (REF_CLK),
      .RST_N   (RST_N),
      .d_in    (SENSE.therm_under),
      .q_out   (therm_under_s)
   );
   // power-fail comparator level
   level_sync u_sync_pfail
   (
      .REF_CLK (REF_CLK),
      .RST_N   (RST_N),
      .d_in    (SENSE.pwr_fail_cmp),
      .q_out   (pwr_fail_s)
   );
   // battery presence level
   level_sync u_sync_batt
   (
      .REF_CLK (REF_CLK),
      .RST_N   (RST_N),
      .d_in    (SENSE.batt_present),
      .q_out   (batt_s)
   );
   // adapter power level
   level_sync u_sync_adapter
   (
      .REF_CLK (REF_CLK),
      .RST_N   (RST_N),
      .d_in    (SENSE.adapter_power_ok),
      .q_out   (adapter_s)
   );

   // command decode; requests are one-cycle strobes, so nothing here is
   // held past the taking edge
   always_comb
   begin
      wr_cur   = is_cmd(CMD_REQ, charger_cmd_pkg::CMD_CURRENT, 1'b1);
      wr_vol   = is_cmd(CMD_REQ, charger_cmd_pkg::CMD_VOLTAGE, 1'b1);
      wr_alarm = is_cmd(CMD_REQ, charger_cmd_pkg::CMD_ALARM, 1'b1);
      alarm_stop = wr_alarm &&
         (|CMD_REQ.data[charger_cmd_pkg::AL_STOP_HI:charger_cmd_pkg::AL_STOP_LO]);
      // each half may arrive now or be remembered from earlier
      // pair completes with either order
      pair_done = (wr_cur || cur_seen_r) && (wr_vol || vol_seen_r) &&
                  (wr_cur || wr_vol);
      inh_clear = DEFAULTS_RESET || !batt_s || !adapter_s || pair_done;
   end

   // status word assembly; lower bits belong to other logic
   always_comb
   begin
      // bits 10..0 stay zero in this bank
      status_word = charger_cmd_pkg::STATUS_LOW;
      status_word[charger_cmd_pkg::ST_THERM_UNDER] = therm_under_s;
      status_word[charger_cmd_pkg::ST_ALARM_INH] = alarm_inh_r;
      status_word[charger_cmd_pkg::ST_PWR_FAIL]  = pwr_fail_s;
      status_word[charger_cmd_pkg::ST_BATT]      = batt_s;
      status_word[charger_cmd_pkg::ST_ADAPTER]   = adapter_s;
   end

   // current request word; hffff is kept as written so the auto code
   // survives until the setting stage
   always_ff @(posedge REF_CLK)
   begin
      // zero at reset, full word taken
      if (!RST_N)
         current_req_r <= charger_cmd_pkg::REQ_RESET;
      else if (wr_cur)
         current_req_r <= CMD_REQ.data;
   end

   // voltage request word; handled like the current word, so a
   // hffff request reaches the setting stage unchanged
   always_ff @(posedge REF_CLK)
   begin
      // zero at reset, full word taken
      if (!RST_N)
         voltage_req_r <= charger_cmd_pkg::REQ_RESET;
      else if (wr_vol)
         voltage_req_r <= CMD_REQ.data;
   end

   // pair tracking; a completed pair or a defaults reset starts over
   // both halves in one cycle cannot happen: one request a cycle
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         cur_seen_r <= 1'b0;
         vol_seen_r <= 1'b0;
      end
      else if (pair_done || DEFAULTS_RESET)
      begin
         cur_seen_r <= 1'b0;
         vol_seen_r <= 1'b0;
      end
      // keep collecting until both halves are in
      else
      begin
         cur_seen_r <= cur_seen_r || wr_cur;
         vol_seen_r <= vol_seen_r || wr_vol;
      end
   end

   // alarm inhibited flag; a new alarm wins over a clear in the same cycle
   // while a battery or adapter is absent the clear stays asserted, so a
   // set in that time lasts one cycle only
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         alarm_inh_r <= 1'b0;
      // a zero upper nibble still counts as an accepted word
      // set on any accepted alarm
      else if (wr_alarm)
         alarm_inh_r <= 1'b1;
      else if (inh_clear)
         alarm_inh_r <= 1'b0;
   end

   // applied current, registered so the output comes from a flop; the
   // limits are levels, so a moved limit applies on the next edge
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         CURRENT_SETTING <= charger_cmd_pkg::REQ_RESET;
         CURRENT_AUTO    <= 1'b0;
      end
      else
      begin
         CURRENT_SETTING <= clamp_req(current_req_r, MAX_CURRENT, SAFE_CURRENT);
         CURRENT_AUTO    <= (current_req_r == charger_cmd_pkg::REQ_MAXIMUM);
      end
   end

   // applied voltage, handled like the current
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         VOLTAGE_SETTING <= charger_cmd_pkg::REQ_RESET;
         VOLTAGE_AUTO    <= 1'b0;
      end
      else
      begin
         VOLTAGE_SETTING <= clamp_req(voltage_req_r, MAX_VOLTAGE, DEVICE_MAX_VOLTAGE);
         VOLTAGE_AUTO    <= (voltage_req_r == charger_cmd_pkg::REQ_MAXIMUM);
      end
   end

   // stop pulse toward the charge controller
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         STOP_CHARGE <= 1'b0;
      else
         STOP_CHARGE <= alarm_stop;
   end

   // wake-up exit pulse; IN_WAKEUP is a level from logic on this clock,
   // so it is taken on the same edge that sees the alarm
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         GO_NOT_CHARGING <= 1'b0;
      else
         GO_NOT_CHARGING <= alarm_stop && IN_WAKEUP;
   end

   // pair pulse; it marks the edge at which the second half arrived
   // and lasts one cycle, as the tracking clears on that same edge
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         PAIR_VALID <= 1'b0;
      else
         PAIR_VALID <= pair_done;
   end

   // mirror of the inhibit flag for the controller
   // it runs one cycle behind status bit 12
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         ALARM_INHIBITED <= 1'b0;
      else
         ALARM_INHIBITED <= alarm_inh_r;
   end

   // command answer, one cycle after the request
   // every request is answered, refused ones with done and no ack, so
   // the protocol engine never waits on a missing answer
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         CMD_RSP <= '0;
      else
      begin
         // idle and refused cycles answer with ack and data at zero
         CMD_RSP.done <= CMD_REQ.valid;
         CMD_RSP.ack  <= 1'b0;
         CMD_RSP.data <= 16'h0000;
         // only a taken request decodes a command
         if (CMD_REQ.valid)
         begin
            case (CMD_REQ.cmd)
               charger_cmd_pkg::CMD_STATUS:
               begin
                  CMD_RSP.ack <= !CMD_REQ.write;
                  if (!CMD_REQ.write)
                     CMD_RSP.data <= status_word;
               end
               charger_cmd_pkg::CMD_CURRENT,
               charger_cmd_pkg::CMD_VOLTAGE,
               charger_cmd_pkg::CMD_ALARM:
                  CMD_RSP.ack <= CMD_REQ.write;
               charger_cmd_pkg::CMD_VERSION:
               begin
                  CMD_RSP.ack <= !CMD_REQ.write;
                  if (!CMD_REQ.write)
                     CMD_RSP.data <= charger_cmd_pkg::VERSION_CODE;
               end
               // unknown command: not acknowledged
               default:
                  CMD_RSP.ack <= 1'b0;
            endcase
         end
      end
   end
endmodule

/* rtl/charger_cmd_pkg.sv */
// shared constants and carrier types for the charger command register bank
package charger_cmd_pkg;
   // command codes seen on the slave command port
   localparam logic [7:0] CMD_STATUS  = 8'h13;  // status word, read only
   localparam logic [7:0] CMD_CURRENT = 8'h14;  // current request, write only
   localparam logic [7:0] CMD_VOLTAGE = 8'h15;  // voltage request, write only
   localparam logic [7:0] CMD_ALARM   = 8'h16;  // alarm warning, write only
   localparam logic [7:0] CMD_VERSION = 8'h3C;  // version word, read only
   // status word field positions
   localparam int ST_THERM_UNDER = 11;
   localparam int ST_ALARM_INH = 12;
   localparam int ST_PWR_FAIL  = 13;
   localparam int ST_BATT      = 14;
   localparam int ST_ADAPTER   = 15;
   // alarm warning upper nibble that stops charging
   localparam int AL_STOP_HI   = 15;
   localparam int AL_STOP_LO   = 12;
   // reset values and special request codes
   localparam logic [15:0] REQ_RESET   = 16'h0000;
   localparam logic [15:0] REQ_MAXIMUM = 16'hFFFF;
   localparam logic [15:0] STATUS_LOW  = 16'h0000; // lower status bits outside this bank
   // version code: value is arbitrary
   localparam logic [15:0] VERSION_CODE = 16'h5A21;

   // one command transaction from the protocol engine
   typedef struct packed {
      logic        valid;  // one-cycle strobe
      logic        write;  // 1 write word, 0 read word
      logic [7:0]  cmd;    // command code
      logic [15:0] data;   // write data
   } cmd_req_t;

   // answer returned to the protocol engine
   typedef struct packed {
      logic        done;   // one-cycle strobe
      logic        ack;    // 1 acknowledge, 0 not-acknowledge
      logic [15:0] data;   // read data
   } cmd_rsp_t;

   // sensed levels from the analog side
   typedef struct packed {
      logic therm_under;   // thermistor below valid range
      logic pwr_fail_cmp;  // battery above 0.9 of adapter voltage
      logic batt_present;  // battery connected
      logic adapter_power_ok;  // adapter charge power available
   } sense_t;
endpackage

/* rtl/level_sync.sv */
`timescale 1ns/1ps
// three-stage synchroniser that accepts a change once stages two and three agree
module level_sync
(
   input  wire logic REF_CLK,
   input  wire logic RST_N,
   input  wire logic d_in,
   output logic      q_out
);
   logic s1_r;   // first stage, read only by s2
   logic s2_r;   // second stage
   logic s3_r;   // third stage

   // shift chain
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end
      else
      begin
         s1_r <= d_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // filtered level moves only when the two late stages agree
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         q_out <= 1'b0;
      else if (s2_r == s3_r)
         q_out <= s3_r;
   end
endmodule

/* verif/charger_command_register_bank_monitor.sv */
`timescale 1ns/1ps
// port-level assertions for the charger command register bank
module charger_command_register_bank_monitor
(
   input wire logic                      REF_CLK,
   input wire logic                      RST_N,
   input wire charger_cmd_pkg::cmd_req_t CMD_REQ,
   input wire charger_cmd_pkg::sense_t   SENSE,
   input wire logic                      IN_WAKEUP,
   input wire logic [15:0]               MAX_CURRENT,
   input wire logic [15:0]               MAX_VOLTAGE,
   input wire logic [15:0]               SAFE_CURRENT,
   input wire logic [15:0]               DEVICE_MAX_VOLTAGE,
   input wire charger_cmd_pkg::cmd_rsp_t CMD_RSP,
   input wire logic [15:0]               CURRENT_SETTING,
   input wire logic [15:0]               VOLTAGE_SETTING,
   input wire logic                      STOP_CHARGE,
   input wire logic                      GO_NOT_CHARGING,
   input wire logic                      ALARM_INHIBITED
);
   // request decode shared by the properties
   wire logic wr     = CMD_REQ.valid && CMD_REQ.write;
   wire logic rd     = CMD_REQ.valid && !CMD_REQ.write;
   wire logic is_st  = CMD_REQ.cmd == charger_cmd_pkg::CMD_STATUS;
   wire logic is_cur = CMD_REQ.cmd == charger_cmd_pkg::CMD_CURRENT;
   wire logic is_vol = CMD_REQ.cmd == charger_cmd_pkg::CMD_VOLTAGE;
   wire logic is_al  = CMD_REQ.cmd == charger_cmd_pkg::CMD_ALARM;
   wire logic is_ver = CMD_REQ.cmd == charger_cmd_pkg::CMD_VERSION;
   wire logic stop_w = wr && is_al && (|CMD_REQ.data[15:12]);
   // applied value: hffff picks the auto value, above limit picks limit
   function automatic logic [15:0] lim(logic [15:0] r, logic [15:0] l, logic [15:0] a);
      return (r == 16'hFFFF) ? a : ((r > l) ? l : r);
   endfunction
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   status_wr_nack_a:
      assert property (wr && is_st |=> CMD_RSP.done && !CMD_RSP.ack)
      else $error("status write was acknowledged");
   req_rd_nack_a:
      assert property (rd && (is_cur || is_vol || is_al) |=> CMD_RSP.done && !CMD_RSP.ack
                       && CMD_RSP.data == 16'h0000)
      else $error("request word read was acknowledged");
   version_rd_a:
      assert property (rd && is_ver |=> CMD_RSP.ack
                       && CMD_RSP.data == charger_cmd_pkg::VERSION_CODE)
      else $error("version word wrong");
   status_live_a:
      assert property ($stable(SENSE) [*7] ##0 (rd && is_st) |=>
                       CMD_RSP.data[15:13] == {$past(SENSE.adapter_power_ok),
                       $past(SENSE.batt_present), $past(SENSE.pwr_fail_cmp)}
                       && CMD_RSP.data[11] == $past(SENSE.therm_under))
      else $error("status bits do not follow sensed levels");
   stop_alarm_a:
      assert property (stop_w |-> ##[1:2] STOP_CHARGE)
      else $error("stop alarm did not stop charging");
   stop_cause_a:
      assert property (STOP_CHARGE |-> $past(stop_w) || $past(stop_w, 2))
      else $error("charging stopped without upper alarm bit");
   inhibit_set_a:
      assert property (stop_w |-> ##[1:3] ALARM_INHIBITED)
      else $error("alarm did not set inhibit");
   wake_go_a:
      assert property (stop_w && IN_WAKEUP |-> ##[1:3] GO_NOT_CHARGING)
      else $error("wake-up alarm did not leave charging");
   cur_setting_a:
      assert property (wr && is_cur |-> ##2
                       CURRENT_SETTING == lim($past(CMD_REQ.data, 2), MAX_CURRENT, SAFE_CURRENT))
      else $error("current setting wrong");
   volt_setting_a:
      assert property (wr && is_vol |-> ##2 VOLTAGE_SETTING ==
                       lim($past(CMD_REQ.data, 2), MAX_VOLTAGE, DEVICE_MAX_VOLTAGE))
      else $error("voltage setting wrong");
endmodule
bind charger_command_register_bank charger_command_register_bank_monitor mon
(
   .REF_CLK(REF_CLK), .RST_N(RST_N), .CMD_REQ(CMD_REQ), .SENSE(SENSE), .IN_WAKEUP(IN_WAKEUP),
   .MAX_CURRENT(MAX_CURRENT), .MAX_VOLTAGE(MAX_VOLTAGE), .SAFE_CURRENT(SAFE_CURRENT),
   .DEVICE_MAX_VOLTAGE(DEVICE_MAX_VOLTAGE), .CMD_RSP(CMD_RSP),
   .CURRENT_SETTING(CURRENT_SETTING), .VOLTAGE_SETTING(VOLTAGE_SETTING),
   .STOP_CHARGE(STOP_CHARGE), .GO_NOT_CHARGING(GO_NOT_CHARGING),
   .ALARM_INHIBITED(ALARM_INHIBITED)
);

/* verif/cmd_host.sv */
`timescale 1ns/1ps
// bus master model issuing one command word at a time
module cmd_host
(
   input  wire logic                      REF_CLK,
   input  wire charger_cmd_pkg::cmd_rsp_t CMD_RSP,
   output charger_cmd_pkg::cmd_req_t      CMD_REQ,
   output logic                           hung
);
   initial CMD_REQ = '0;
   initial hung = 1'b0;
   // valid stands for one taking edge, then the fields are scrambled
   task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
                       output logic ack, output logic [15:0] q);
      logic [15:0] dd;
      dd = d;
      // error code driven high on alarm words
      if (c == charger_cmd_pkg::CMD_ALARM)
         dd[3:0] = 4'hF;
      @(negedge REF_CLK);
      CMD_REQ = {1'b1, wr, c, dd};
      @(negedge REF_CLK);
      CMD_REQ = {1'b0, ~wr, ~c, ~dd};
      ack = 1'b0;
      q = 16'h0000;
      hung = 1'b1;
      // bounded wait for the one-cycle answer
      repeat (4)
      begin
         if (hung && CMD_RSP.done === 1'b1)
         begin
            ack = CMD_RSP.ack;
            q = CMD_RSP.data;
            hung = 1'b0;
         end
         if (hung)
            @(negedge REF_CLK);
      end
   endtask
endmodule

/* verif/charger_command_register_bank_bench.sv */
`timescale 1ns/1ps
// self-checking bench for the charger command register bank
module charger_command_register_bank_bench;
   logic                      ref_clk = 1'b0;
   logic                      rst_n = 1'b0;
   charger_cmd_pkg::cmd_req_t cmd_req;
   charger_cmd_pkg::cmd_rsp_t cmd_rsp;
   charger_cmd_pkg::sense_t   sense = '0;
   logic                      defaults_reset = 1'b0;
   logic                      in_wakeup = 1'b0;
   logic [15:0]               max_cur = 16'h0BB8, max_volt = 16'h0BB9; // limits
   logic [15:0]               safe_cur = 16'h0FA0, dev_volt = 16'h2EE0; // auto values
   logic [15:0]               cur_set, volt_set;
   logic                      cur_auto, volt_auto, stop, go, pair, inh;
   logic                      stop_seen, go_seen, pair_seen;
   int                        error_cnt = 0;
   int                        n_compared = 0;
   // request table with boundary values and expected applied settings
   logic [15:0] reqv [5]   = '{16'h0064, 16'h0BB8, 16'h0BB9, 16'hFFFE, 16'hFFFF};
   logic [15:0] cur_e [5]  = '{16'h0064, 16'h0BB8, 16'h0BB8, 16'h0BB8, 16'h0FA0};
   logic [15:0] volt_e [5] = '{16'h0064, 16'h0BB8, 16'h0BB9, 16'h0BB9, 16'h2EE0};
   logic [7:0]  rf_cmd [6] = '{8'h14, 8'h15, 8'h16, 8'h13, 8'h3C, 8'h00};
   logic        rf_wr [6]  = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   logic [3:0]  sv [4]     = '{4'h0, 4'hA, 4'h5, 4'hF};
   always #5 ref_clk = ~ref_clk;
   cmd_host host (.REF_CLK(ref_clk), .CMD_RSP(cmd_rsp), .CMD_REQ(cmd_req), .hung());
   // limits are levels that the bench may move
   charger_command_register_bank dut
   (
      .REF_CLK(ref_clk), .RST_N(rst_n), .CMD_REQ(cmd_req), .SENSE(sense),
      .DEFAULTS_RESET(defaults_reset), .IN_WAKEUP(in_wakeup), .MAX_CURRENT(max_cur),
      .MAX_VOLTAGE(max_volt), .SAFE_CURRENT(safe_cur), .DEVICE_MAX_VOLTAGE(dev_volt),
      .CMD_RSP(cmd_rsp), .CURRENT_SETTING(cur_set), .VOLTAGE_SETTING(volt_set),
      .CURRENT_AUTO(cur_auto), .VOLTAGE_AUTO(volt_auto), .STOP_CHARGE(stop),
      .GO_NOT_CHARGING(go), .PAIR_VALID(pair), .ALARM_INHIBITED(inh)
   );
   // catchers so one-cycle pulses are not missed
   always @(posedge ref_clk)
   begin
      if (stop === 1'b1)
         stop_seen = 1'b1;
      if (go === 1'b1)
         go_seen = 1'b1;
      if (pair === 1'b1)
         pair_seen = 1'b1;
   end
   task automatic summarize();
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // one transfer; a missing answer ends the run
   task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
                       input logic ae, input logic [15:0] qe);
      logic        a;
      logic [15:0] q;
      host.xfer(wr, c, d, a, q);
      if (host.hung)
      begin
         error_cnt++;
         summarize();
      end
      check(16'(a), 16'(ae));
      if (!wr)
         check(q, qe);
   endtask
   // expected status word from the levels now applied
   function automatic logic [15:0] st_e(input logic i);
      return {sense.adapter_power_ok, sense.batt_present, sense.pwr_fail_cmp, i,
              sense.therm_under, 11'h000};
   endfunction
   initial
   begin
      idle(8);
      rst_n = 1'b1;
      idle(6);
      check(cur_set, 16'h0000);
      check(volt_set, 16'h0000);
      xfer(1'b0, 8'h3C, 16'h0000, 1'b1, charger_cmd_pkg::VERSION_CODE);
      for (int i = 0; i < 6; i++)
         xfer(rf_wr[i], rf_cmd[i], 16'hFFFF, 1'b0, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         sense = sv[i];
         idle(8);
         xfer(1'b0, 8'h13, 16'h0000, 1'b1, st_e(1'b0));
      end
      for (int i = 0; i < 5; i++)
      begin
         xfer(1'b1, 8'h14, reqv[i], 1'b1, 16'h0000);
         xfer(1'b1, 8'h15, reqv[i], 1'b1, 16'h0000);
         idle(3);
         check(cur_set, cur_e[i]);
         check(volt_set, volt_e[i]);
         check(16'(cur_auto), 16'(i == 4));
         check(16'(volt_auto), 16'(i == 4));
      end
      in_wakeup = 1'b1;
      for (int i = 12; i < 16; i++)
      begin
         stop_seen = 1'b0;
         go_seen = 1'b0;
         xfer(1'b1, 8'h16, 16'h0001 << i, 1'b1, 16'h0000);
         idle(3);
         check(16'(stop_seen), 16'h0001);
         check(16'(go_seen), 16'h0001);
         xfer(1'b0, 8'h13, 16'h0000, 1'b1, st_e(1'b1));
         check(16'(inh), 16'h0001);
      end
      stop_seen = 1'b0;
      xfer(1'b1, 8'h16, 16'h0FF0, 1'b1, 16'h0000);
      idle(3);
      check(16'(stop_seen), 16'h0000);
      xfer(1'b0, 8'h13, 16'h0000, 1'b1, st_e(1'b1));
      pair_seen = 1'b0;
      xfer(1'b1, 8'h15, 16'h0064, 1'b1, 16'h0000);
      idle(3);
      check(16'(pair_seen), 16'h0000);
      xfer(1'b1, 8'h14, 16'h0064, 1'b1, 16'h0000);
      idle(3);
      check(16'(pair_seen), 16'h0001);
      xfer(1'b0, 8'h13, 16'h0000, 1'b1, st_e(1'b0));
      in_wakeup = 1'b0;
      go_seen = 1'b0;
      xfer(1'b1, 8'h16, 16'h8000, 1'b1, 16'h0000);
      idle(3);
      check(16'(go_seen), 16'h0000);
      defaults_reset = 1'b1;
      idle(1);
      defaults_reset = 1'b0;
      idle(3);
      xfer(1'b0, 8'h13, 16'h0000, 1'b1, st_e(1'b0));
      for (int i = 0; i < 2; i++)
      begin
         sense = 4'hF;
         idle(8);
         xfer(1'b1, 8'h16, 16'h1000, 1'b1, 16'h0000);
         sense = (i == 0) ? 4'hD : 4'hE;
         idle(8);
         xfer(1'b0, 8'h13, 16'h0000, 1'b1, st_e(1'b0));
         check(16'(inh), 16'h0000);
      end
      max_cur = 16'h0050;
      max_volt = 16'h0050;
      idle(3);
      check(cur_set, 16'h0050);
      check(volt_set, 16'h0050);
      summarize();
   end
endmodule
